//--- serial_ctrl_init_sequencer.sv
// device-side serial control port: framing, decode, init register, chain repeat
//
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/100ps
`include "serial_ctrl_params.svh"

module serial_ctrl_init_sequencer (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // serial control pins from the controller
  input wire logic serial_clk,
  input wire logic frame_cmd,
  // chain pin toward the controller
  input wire logic chain_port_in_rx,
  output logic chain_port_in_tx,
  output logic chain_port_in_oe,
  // chain pin toward the next device
  input wire logic chain_port_out_rx,
  output logic chain_port_out_tx,
  output logic chain_port_out_oe,
  // local register port
  input wire logic [1:0] loc_addr,
  input wire logic [15:0] loc_wdata,
  input wire logic loc_wr,
  input wire logic loc_rd,
  output logic [15:0] loc_rdata,
  // state seen by the rest of the device
  output logic [5:0] serial_id,
  output logic repeater_bit,
  output logic reset_bit,
  output logic fast_mode
);
  import serial_ctrl_pkg::*;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [`SYNC_PINS-1:0] pin_raw;
  logic [`SYNC_PINS-1:0] s1_ff;
  logic [`SYNC_PINS-1:0] s2_ff;
  logic [`SYNC_PINS-1:0] s3_ff;
  logic [`SYNC_PINS-1:0] lvl_ff;
  assign pin_raw = {chain_port_out_rx, chain_port_in_rx, frame_cmd, serial_clk};

  // level only moves once stages two and three agree, filtering a glitch
  genvar gi;
  generate
    for (gi = 0; gi < `SYNC_PINS; gi++)
    begin : g_sync
      always_ff @(posedge core_clk or posedge rst)
      begin
        if (rst)
        begin
          s1_ff[gi] <= 1'b0;
          s2_ff[gi] <= 1'b0;
          s3_ff[gi] <= 1'b0;
          lvl_ff[gi] <= 1'b0;
        end
        else
        begin
          s1_ff[gi] <= pin_raw[gi];
          s2_ff[gi] <= s1_ff[gi];
          s3_ff[gi] <= s2_ff[gi];
          if (s2_ff[gi] == s3_ff[gi])
            lvl_ff[gi] <= s3_ff[gi];
        end
      end
    end
  endgenerate

  logic sck_stable;
  logic sck_rise;
  logic sck_fall;
  logic cmd_lvl;
  logic din;
  logic dback;
  // edges of the serial clock as seen by core_clk
  assign sck_stable = (s2_ff[0] == s3_ff[0]);
  assign sck_rise = sck_stable && s3_ff[0] && !lvl_ff[0];
  assign sck_fall = sck_stable && !s3_ff[0] && lvl_ff[0];
  assign cmd_lvl = lvl_ff[1];
  assign din = lvl_ff[2];
  assign dback = lvl_ff[3];

  // ----------------------------------------
  // framing and packet sequencing
  // ----------------------------------------
  pkt_state_e state_ff;
  logic [7:0] frame_ff;
  logic [3:0] cnt_ff;
  logic [15:0] shift_ff;
  logic [4:0] guard_ff;
  logic sel_ff;
  logic is_read_ff;
  logic [11:0] addr_ff;
  logic [15:0] rd_ff;
  logic [15:0] init_ff;
  logic reset_bit_ff;
  logic fast_ff;
  logic [15:0] nxt_shift;
  logic frame_hit;
  logic pkt_end;
  request_packet_s req;

  // frame sampled on both serial clock edges
  assign frame_hit = sck_fall && ({frame_ff[6:0], cmd_lvl} == `FRAME_PATTERN);
  assign nxt_shift = {shift_ff[14:0], din};
  assign pkt_end = sck_fall && (cnt_ff == `PKT_LAST);
  assign req = request_packet_s'(nxt_shift);

  // reserved bits are ignored; the controller keeps them zero
  function automatic logic is_sel(input request_packet_s r, input logic [5:0] sid);
    is_sel = r.broadcast_flag || ({r.dev_hi, r.dev_lo} == sid);
  endfunction : is_sel

  logic req_done;
  logic req_sel;
  assign req_done = pkt_end && (state_ff == ST_REQ);
  assign req_sel = is_sel(req, serial_id);

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      frame_ff <= 8'h00;
    else if (sck_rise || sck_fall)
      frame_ff <= {frame_ff[6:0], cmd_lvl};
  end

  // bits sampled on the falling edge, sixteen per packet
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_ff <= 4'h0;
      shift_ff <= 16'h0000;
    end
    else if (frame_hit && state_ff == ST_IDLE)
      cnt_ff <= 4'h0;
    else if (sck_fall && state_ff != ST_IDLE)
    begin
      cnt_ff <= cnt_ff + 4'h1;
      shift_ff <= nxt_shift;
    end
  end

  // packet order differs for read and write; control commands stop after request
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_ff <= ST_IDLE;
      sel_ff <= 1'b0;
      is_read_ff <= 1'b0;
      addr_ff <= 12'h000;
    end
    else
    begin
      case (state_ff)
        ST_IDLE:
          if (frame_hit && guard_ff == 5'h00)
            state_ff <= ST_REQ;
        ST_REQ:
          if (pkt_end)
          begin
            sel_ff <= req_sel;
            is_read_ff <= (req.serial_opcode == OP_READ);
            if (req.serial_opcode == OP_READ || req.serial_opcode == OP_WRITE)
              state_ff <= ST_ADDR;
            else
              state_ff <= ST_IDLE;
          end
        ST_ADDR:
          if (pkt_end)
          begin
            addr_ff <= nxt_shift[11:0];
            state_ff <= is_read_ff ? ST_INTV : ST_DATA;
          end
        ST_DATA:
          if (pkt_end)
            state_ff <= ST_INTV;
        ST_INTV:
          if (pkt_end)
            state_ff <= is_read_ff ? ST_RDATA : ST_IDLE;
        ST_RDATA:
          if (pkt_end)
            state_ff <= ST_IDLE;
        default:
          state_ff <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // command effects and the init register
  // ----------------------------------------
  logic wr_commit;
  assign wr_commit = pkt_end && state_ff == ST_DATA && sel_ff && addr_ff == `INIT_ADDR;

  // guard counts serial cycles; early frames are dropped rather than half-decoded
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      guard_ff <= 5'h00;
    else if (req_done && req_sel && req.serial_opcode == OP_SET_RESET)
      guard_ff <= `WAIT_SET_RESET_CMD;
    else if (req_done && req_sel &&
             (req.serial_opcode == OP_CLEAR_RESET || req.serial_opcode == OP_FAST_CLOCK))
      guard_ff <= `WAIT_SHORT;
    else if (sck_fall && guard_ff != 5'h00)
      guard_ff <= guard_ff - 5'h01;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      reset_bit_ff <= 1'b0;
      fast_ff <= 1'b0;
    end
    else if (req_done && req_sel)
    begin
      if (req.serial_opcode == OP_SET_RESET)
        reset_bit_ff <= 1'b1;
      else if (req.serial_opcode == OP_CLEAR_RESET)
        reset_bit_ff <= 1'b0;
      else if (req.serial_opcode == OP_FAST_CLOCK)
        fast_ff <= 1'b1;
    end
  end

  // held at reset value while the reset bit is set; id is init bits 14 and 4:0, set by serial or local write
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      init_ff <= `INIT_RST;
    else if (reset_bit_ff || (req_done && req_sel && req.serial_opcode == OP_SET_RESET))
      init_ff <= `INIT_RST;
    else if (wr_commit)
      init_ff <= nxt_shift;
    else if (loc_wr && loc_addr == `LOC_INIT)
      init_ff <= loc_wdata;
  end

  // read data captured when the address packet completes
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      rd_ff <= 16'h0000;
    else if (pkt_end && state_ff == ST_ADDR)
      rd_ff <= (nxt_shift[11:0] == `INIT_ADDR) ? init_ff : 16'h0000;
    else if (sck_fall && state_ff == ST_RDATA)
      rd_ff <= {rd_ff[14:0], 1'b0};
  end

  // ----------------------------------------
  // chain pins and outputs
  // ----------------------------------------
  logic own_read;
  assign own_read = (state_ff == ST_RDATA) && sel_ff;

  // read data heads back toward the controller; other packets repeat downstream
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      chain_port_in_tx <= 1'b0;
      chain_port_in_oe <= 1'b0;
      chain_port_out_tx <= 1'b0;
      chain_port_out_oe <= 1'b0;
    end
    else
    begin
      chain_port_in_oe <= own_read || (state_ff == ST_RDATA && repeater_bit);
      chain_port_in_tx <= own_read ? rd_ff[15] : dback;
      chain_port_out_oe <= init_ff[`INIT_SRP_POS] && state_ff != ST_RDATA;
      chain_port_out_tx <= din;
    end
  end

  // status mirrors; outputs come straight from flops
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      serial_id <= 6'h00;
      repeater_bit <= 1'b0;
      reset_bit <= 1'b0;
      fast_mode <= 1'b0;
      loc_rdata <= 16'h0000;
    end
    else
    begin
      serial_id <= {init_ff[`INIT_SID_HI_POS], init_ff[4:0]};
      repeater_bit <= init_ff[`INIT_SRP_POS];
      reset_bit <= reset_bit_ff;
      fast_mode <= fast_ff;
      if (loc_rd)
        loc_rdata <= (loc_addr == `LOC_INIT) ? init_ff :
                     (loc_addr == `LOC_STAT) ? {13'h0000, guard_ff != 5'h00, fast_ff, reset_bit_ff} :
                     16'h0000;
      else
        loc_rdata <= 16'h0000;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_set_reset_cmd_resets;
    @(posedge core_clk) disable iff (rst)
      req_done && req_sel && req.serial_opcode == OP_SET_RESET
      |=> reset_bit_ff && init_ff == `INIT_RST && guard_ff == `WAIT_SET_RESET_CMD;
  endproperty
  a_set_reset_cmd_resets: assert property (p_set_reset_cmd_resets) else $error("set reset failed");

  property p_clear_reset_cmd_clears;
    @(posedge core_clk) disable iff (rst)
      req_done && req_sel && req.serial_opcode == OP_CLEAR_RESET
      |=> !reset_bit_ff && guard_ff == `WAIT_SHORT ##1 init_ff == `INIT_RST;
  endproperty
  a_clear_reset_cmd_clears: assert property (p_clear_reset_cmd_clears) else $error("clear reset failed");

  property p_fast_clock_cmd_fast;
    @(posedge core_clk) disable iff (rst)
      req_done && req_sel && req.serial_opcode == OP_FAST_CLOCK
      |=> fast_ff ##1 fast_mode;
  endproperty
  a_fast_clock_cmd_fast: assert property (p_fast_clock_cmd_fast) else $error("fast clock not set");

  property p_nop_idle;
    @(posedge core_clk) disable iff (rst)
      req_done && req.serial_opcode == OP_NOP |=> state_ff == ST_IDLE && $stable(init_ff);
  endproperty
  a_nop_idle: assert property (p_nop_idle) else $error("nop had an effect");

  property p_mismatch;
    @(posedge core_clk) disable iff (rst)
      req_done && !req.broadcast_flag && {req.dev_hi, req.dev_lo} != serial_id |=> !sel_ff;
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("unmatched device selected");

  property p_bcast;
    @(posedge core_clk) disable iff (rst)
      req_done && req.broadcast_flag |=> sel_ff;
  endproperty
  a_bcast: assert property (p_bcast) else $error("broadcast not taken");

  property p_no_forward;
    @(posedge core_clk) disable iff (rst)
      !init_ff[`INIT_SRP_POS] |=> !chain_port_out_oe;
  endproperty
  a_no_forward: assert property (p_no_forward) else $error("forwarding with repeater off");

  property p_write16;
    @(posedge core_clk) disable iff (rst)
      wr_commit && !reset_bit_ff |=> init_ff == $past(nxt_shift) ##1 serial_id ==
        {init_ff[`INIT_SID_HI_POS], init_ff[4:0]};
  endproperty
  a_write16: assert property (p_write16) else $error("serial write lost");

  property p_silent;
    @(posedge core_clk) disable iff (rst)
      state_ff == ST_RDATA && !sel_ff && !repeater_bit |=> !chain_port_in_oe;
  endproperty
  a_silent: assert property (p_silent) else $error("unselected device drove data");

  c_read: cover property (@(posedge core_clk) state_ff == ST_RDATA && sel_ff);
  c_write: cover property (@(posedge core_clk) wr_commit);
  c_set_reset_cmd: cover property (@(posedge core_clk) reset_bit_ff ##[1:1000] !reset_bit_ff);
endmodule : serial_ctrl_init_sequencer

//--- serial_ctrl_init_sequencer_test.sv
// self-checking bench: controller model and two chained devices
`timescale 1ns/100ps
`include "serial_ctrl_params.svh"

module serial_ctrl_init_sequencer_test;
  import serial_ctrl_pkg::*;
  logic core_clk;
  logic rst = 1'b1;
  logic [1:0] loc_addr = 2'h0;
  logic [15:0] loc_wdata = 16'h0000;
  logic [1:0] loc_wr = 2'b00;
  logic [1:0] loc_rd = 2'b00;
  logic [15:0] rdata0;
  logic [15:0] rdata1;
  logic [5:0] id0;
  logic [5:0] id1;
  logic rep0, rep1, rbit0, fast0;
  logic sclk, fcmd, m_tx, tx0, oe0, otx0, ooe0, tx1, oe1;
  logic last1 = 1'b0;
  logic link0;
  logic link1;
  int error_cnt = 0;
  int check_count = 0;
  int cyc_cnt = 0;

  // ----------------------------------------
  // wiring and clock
  // ----------------------------------------
  // chain wires: whoever enables drives, else the controller on link0 and the inverse of the last level on link1
  assign link0 = oe0 ? tx0 : m_tx;
  assign link1 = ooe0 ? otx0 : (oe1 ? tx1 : ~last1);
  always @(posedge core_clk) if (ooe0 | oe1) last1 <= link1;

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  serial_ctrl_model ctl_u (.serial_clk(sclk), .frame_cmd(fcmd), .sio_tx(m_tx), .sio_rx(link0));
  serial_ctrl_init_sequencer dut_u (.core_clk, .rst, .serial_clk(sclk), .frame_cmd(fcmd),
    .chain_port_in_rx(link0), .chain_port_in_tx(tx0), .chain_port_in_oe(oe0),
    .chain_port_out_rx(link1), .chain_port_out_tx(otx0), .chain_port_out_oe(ooe0),
    .loc_addr, .loc_wdata, .loc_wr(loc_wr[0]), .loc_rd(loc_rd[0]), .loc_rdata(rdata0),
    .serial_id(id0), .repeater_bit(rep0), .reset_bit(rbit0), .fast_mode(fast0));
  // second device, last in the chain
  serial_ctrl_init_sequencer dut_b_u (.core_clk, .rst, .serial_clk(sclk), .frame_cmd(fcmd),
    .chain_port_in_rx(link1), .chain_port_in_tx(tx1), .chain_port_in_oe(oe1),
    .chain_port_out_rx(~last1), .chain_port_out_tx(), .chain_port_out_oe(),
    .loc_addr, .loc_wdata, .loc_wr(loc_wr[1]), .loc_rd(loc_rd[1]), .loc_rdata(rdata1),
    .serial_id(id1), .repeater_bit(rep1), .reset_bit(), .fast_mode());

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk

  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim

  task automatic lw(input logic s, input logic [1:0] a, input logic [15:0] d);
    @(posedge core_clk);
    loc_addr <= a;
    loc_wdata <= d;
    loc_wr <= s ? 2'b10 : 2'b01;
    @(posedge core_clk);
    loc_wr <= 2'b00;
    #1; // leave off the edge so serial pins never move on it
  endtask : lw

  task automatic lr(input logic s, input logic [1:0] a, output logic [15:0] d);
    @(posedge core_clk);
    loc_addr <= a;
    loc_rd <= s ? 2'b10 : 2'b01;
    @(posedge core_clk);
    loc_rd <= 2'b00;
    #1 d = s ? rdata1 : rdata0;
  endtask : lr

  // effects land a few core cycles after the last fall
  task automatic settle;
    repeat (8) @(posedge core_clk);
    #1;
  endtask : settle

  // init word that gives an id and opens the repeater
  function automatic logic [15:0] id_word(input logic [5:0] x);
    return {1'b0, x[5], 6'h00, 1'b1, 2'b00, x[4:0]};
  endfunction : id_word

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_local;
    logic [15:0] d;
    lr(1'b0, `LOC_STAT, d);
    chk("status", d, 16'h0000);
    lw(1'b0, `LOC_INIT, 16'h4005);
    lr(1'b0, `LOC_INIT, d);
    chk("init", d, 16'h4005);
    #10 chk("rdata after", rdata0, 16'h0000);
    chk("id", 16'(id0), 16'h0025);
    lw(1'b0, 2'h2, 16'hffff);
    lr(1'b0, 2'h2, d);
    chk("unmapped", d, 16'h0000);
    $display("test local done");
  endtask : t_local

  // early clear is dropped inside the wait; reserved code is ignored
  task automatic t_reset;
    logic [15:0] d;
    ctl_u.req(OP_SET_RESET, 1'b1, 6'h00);
    settle;
    chk("reset set", 16'(rbit0), 16'h0001);
    chk("id cleared", 16'(id0), 16'h0000);
    ctl_u.req(OP_CLEAR_RESET, 1'b1, 6'h00);
    settle;
    chk("early clear", 16'(rbit0), 16'h0001);
    ctl_u.req(4'h3, 1'b1, 6'h00);
    settle;
    chk("code 0011", 16'(rbit0), 16'h0001);
    ctl_u.req(OP_CLEAR_RESET, 1'b1, 6'h00);
    settle;
    chk("reset clear", 16'(rbit0), 16'h0000);
    lr(1'b0, `LOC_INIT, d);
    chk("init kept", d, 16'h0000);
    ctl_u.idle(4);
    ctl_u.req(OP_FAST_CLOCK, 1'b1, 6'h00);
    ctl_u.idle(4);
    settle;
    chk("fast", 16'(fast0), 16'h0001);
    lr(1'b0, `LOC_STAT, d);
    chk("status", d, 16'h0002);
    $display("test reset sequence done");
  endtask : t_reset

  task automatic t_ops;
    for (int i = 0; i < 16; i++)
      if (!(i inside {0, 1, 2, 4, 11}))
        ctl_u.req(4'(i), 1'b1, 6'h00);
    settle;
    chk("fast kept", 16'(fast0), 16'h0001);
    chk("reset kept", 16'(rbit0), 16'h0000);
    chk("id kept", 16'(id0), 16'h0000);
    $display("test codes done");
  endtask : t_ops

  // two devices, id loop as the controller runs it; well under the chain limit
  task automatic t_ids;
    lw(1'b1, `LOC_INIT, 16'h401f); // far device already holds id 3f, repeater off
    ctl_u.wr(1'b1, 6'h00, `INIT_ADDR, 16'h401f);
    settle;
    chk("top id", 16'(id0), 16'h003f);
    chk("link cut", 16'(rep0), 16'h0000);
    ctl_u.wr(1'b0, 6'h3f, `INIT_ADDR, id_word(6'h00));
    settle;
    chk("id pass 0", 16'(id0), 16'h0000);
    chk("rep pass 0", 16'(rep0), 16'h0001);
    chk("far untouched", 16'(id1), 16'h003f);
    ctl_u.wr(1'b0, 6'h3f, `INIT_ADDR, id_word(6'h01));
    settle;
    chk("near kept", 16'(id0), 16'h0000);
    chk("far id", 16'(id1), 16'h0001);
    chk("far rep", 16'(rep1), 16'h0001);
    $display("test id loop done");
  endtask : t_ids

  // serial clock stands still through the settle pause; bank warm-up is on the memory side
  task automatic t_pause;
    #200_000;
    chk("pause id", 16'(id1), 16'h0001);
    chk("pause drive", 16'({oe0, oe1, ooe0}), 16'h0001);
    $display("test settle pause done");
  endtask : t_pause

  task automatic t_read;
    logic [15:0] d;
    ctl_u.rd(6'h01, `INIT_ADDR, d);
    chk("far read", d, id_word(6'h01));
    ctl_u.rd(6'h00, `INIT_ADDR, d);
    chk("near read", d, id_word(6'h00));
    ctl_u.wr(1'b0, 6'h01, `INIT_ADDR, 16'h4081);
    settle;
    chk("far write", 16'(id1), 16'h0021);
    chk("near id", 16'(id0), 16'h0000);
    $display("test read write done");
  endtask : t_read

  // ----------------------------------------
  // run and hang guard
  // ----------------------------------------
  always @(posedge core_clk)
  begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 50000)
    begin
      error_cnt++;
      end_sim;
    end
  end

  initial
  begin
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    t_local;
    t_reset;
    t_ops;
    t_ids;
    t_pause;
    t_read;
    end_sim;
  end
endmodule : serial_ctrl_init_sequencer_test

//--- serial_ctrl_model.sv
// controller model that drives the serial control pins of the first device
`timescale 1ns/100ps

module serial_ctrl_model (
  // serial pins toward the first device
  output logic serial_clk,
  output logic frame_cmd,
  output logic sio_tx,
  // resolved chain line, read back
  input wire logic sio_rx
);
  import serial_ctrl_pkg::*;

  // ----------------------------------------
  // serial cycles
  // ----------------------------------------
  // clock stands low outside frames
  initial
  begin
    serial_clk = 1'b0;
    frame_cmd = 1'b0;
    sio_tx = 1'b0;
  end

  // one 160 ns cycle; the line is read just before the fall
  task automatic cyc(input logic c, input logic d, output logic s);
    frame_cmd = c;
    sio_tx = d;
    #40 serial_clk = 1'b1;
    #78 s = sio_rx; // read off the core edge, after the device's launch has settled
    #2 serial_clk = 1'b0;
    #40;
  endtask : cyc

  // released line shows a changing level, never a stale bit
  task automatic idle(input int n);
    logic s;
    repeat (n) cyc(1'b0, ~sio_tx, s);
  endtask : idle

  // sixteen bits, cycle 0 first
  task automatic pkt(input logic [15:0] v);
    logic s;
    for (int i = 15; i >= 0; i--) cyc(1'b0, v[i], s);
  endtask : pkt

  // frame then request packet; alone it is a reset or clock command
  task automatic req(input logic [3:0] op, input logic bc, input logic [5:0] dev);
    request_packet_s p;
    logic s;
    p = '0;
    p.dev_hi = dev[5];
    p.serial_opcode = op;
    p.broadcast_flag = bc;
    p.dev_lo = dev[4:0];
    cyc(1'b1, ~sio_tx, s);
    cyc(1'b1, ~sio_tx, s);
    cyc(1'b0, ~sio_tx, s);
    cyc(1'b0, ~sio_tx, s);
    pkt(p);
  endtask : req

  // write: request, address, data, interval
  task automatic wr(input logic bc, input logic [5:0] dev, input logic [11:0] a,
                    input logic [15:0] d);
    req(OP_WRITE, bc, dev);
    pkt({4'h0, a});
    pkt(d);
    pkt(16'h0000);
  endtask : wr

  // read: request, address, interval, then the line is released
  task automatic rd(input logic [5:0] dev, input logic [11:0] a, output logic [15:0] d);
    req(OP_READ, 1'b0, dev);
    pkt({4'h0, a});
    pkt(16'h0000);
    for (int i = 15; i >= 0; i--) cyc(1'b0, ~sio_tx, d[i]);
  endtask : rd
endmodule : serial_ctrl_model

//--- serial_ctrl_params.svh
// constants for the serial control-register sequencer
`ifndef SERIAL_CTRL_PARAMS_SVH
`define SERIAL_CTRL_PARAMS_SVH
`define INIT_ADDR 12'h021
`define INIT_RST 16'h0000
`define INIT_SRP_POS 7
`define INIT_SID_HI_POS 14
`define FRAME_PATTERN 8'hF0
`define PKT_LAST 4'hF
`define WAIT_SET_RESET_CMD 5'h10
`define WAIT_SHORT 5'h04
`define LOC_INIT 2'h0
`define LOC_STAT 2'h1
`define SYNC_PINS 4
`endif

//--- serial_ctrl_pkg.sv
// types for the serial control-register sequencer
package serial_ctrl_pkg;
  typedef enum logic [3:0] {
    OP_READ = 4'h0,
    OP_WRITE = 4'h1,
    OP_SET_RESET = 4'h2,
    OP_FAST_CLOCK = 4'h4,
    OP_CLEAR_RESET = 4'hB,
    OP_NOP = 4'hF
  } serial_opcode_e;
  // request packet, cycle 0 in bit 15
  typedef struct packed {
    logic [4:0] rsv;
    logic dev_hi;
    logic [3:0] serial_opcode;
    logic broadcast_flag;
    logic [4:0] dev_lo;
  } request_packet_s;
  typedef enum {ST_IDLE, ST_REQ, ST_ADDR, ST_DATA, ST_INTV, ST_RDATA} pkt_state_e;
endpackage : serial_ctrl_pkg
